// ===== inc/apm_pkg.sv
// Constants shared by the amplifier power-mode sequencer and its supply monitor.
// Assumes a 125 MHz reference clock and supply levels given as millivolt codes.
package apm_pkg;
   localparam int          CLK_MHZ           = 125;
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 16;
   localparam int          MV_W              = 13;

   // Register offsets (byte addresses)
   localparam logic [7:0]  OFF_ID            = 8'h00;
   localparam logic [7:0]  OFF_SYSTEM_CONTROL_REG       = 8'h04;
   localparam logic [7:0]  OFF_SYSTEM_STATUS_REG         = 8'h08;
   localparam logic [7:0]  OFF_IRQST         = 8'h0c;
   localparam logic [7:0]  OFF_IRQMASK       = 8'h10;
   localparam logic [7:0]  OFF_AUDCFG        = 8'h14;

   localparam logic [15:0] SOFT_RESET_KEY    = 16'h55aa;
   // Arbitrary identification value
   localparam logic [15:0] ID_VALUE          = 16'h0a5c;

   // System control fields
   localparam int          SC_SYS_PD_BIT     = 0;
   localparam int          SC_AMP_PD_BIT     = 1;
   localparam int          SC_HARD_MUTE_BIT  = 2;
   localparam logic [2:0]  SYSTEM_CONTROL_REG_RESET     = 3'h7;

   // System status fields
   localparam int          ST_MODE_LSB       = 0;
   localparam int          ST_PLL_LOCK_BIT   = 2;
   localparam int          ST_SWS_BIT        = 3;
   localparam int          ST_AUDCFG_OK_BIT  = 4;
   localparam int          ST_MUTED_BIT      = 5;

   // Interrupt status and mask fields
   localparam int          IRQ_W             = 4;
   localparam int          IRQ_STANDBY_BIT   = 0;
   localparam int          IRQ_PLL_BIT       = 1;
   localparam int          IRQ_SWS_BIT       = 2;
   localparam int          IRQ_CFGERR_BIT    = 3;

   // Audio port configuration: slot count in [3:0], rate code in [7:4]
   localparam int          AC_SLOTS_LSB      = 0;
   localparam int          AC_RATE_LSB       = 4;
   localparam logic [3:0]  AC_SLOTS_RESET    = 4'h2;
   localparam logic [3:0]  RATE_8K           = 4'h0;
   localparam logic [3:0]  RATE_32K          = 4'h6;
   localparam logic [3:0]  RATE_44K1         = 4'h7;
   localparam logic [3:0]  RATE_48K          = 4'h8;
   localparam logic [3:0]  RATE_96K          = 4'h9;
   localparam logic [3:0]  MAX_SLOTS         = 4'h8;
   localparam logic [3:0]  MAX_SLOTS_96K     = 4'h4;

   // Supply thresholds in millivolts
   localparam logic [12:0] VDD_POR_MV        = 13'd2100;
   localparam logic [12:0] VDD_OK_MV         = 13'd3000;
   localparam logic [12:0] DVDD_POR_MV       = 13'd1100;
   localparam logic [12:0] DVDD_OK_MV        = 13'd1650;

   // Boost and amplifier start-up time before switching is stable
   localparam int          STARTUP_TIME_US   = 1000;

   typedef enum logic [1:0] {
      MODE_POWER_DOWN  = 2'b00,
      MODE_STANDBY     = 2'b01,
      MODE_CONFIGURING = 2'b10,
      MODE_OPERATING   = 2'b11
   } apm_mode_e;
endpackage

// ===== hdl/apm_supply_mon.sv
// Supply monitor: a good flag with hysteresis and a power-on pulse.
// Assumes the level code is synchronous to ref_clk.
`timescale 1ns/1ps
module apm_supply_mon
   import apm_pkg::*;
#(
   parameter logic [12:0] POR_MV = 13'd0,
   parameter logic [12:0] OK_MV  = 13'd0
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [MV_W-1:0]   levelMv,
   output logic                   supplyOk,
   output logic                   porPulse
);
   logic seenZero_reg;

   // Good only above the upper figure, lost only below the lower one
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         supplyOk <= 1'b0;
      end else if (levelMv < POR_MV) begin
         supplyOk <= 1'b0;
      end else if (levelMv > OK_MV) begin
         supplyOk <= 1'b1;
      end
   end

   // A ramp counts only when it starts from zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seenZero_reg <= 1'b0;
         porPulse     <= 1'b0;
      end else begin
         porPulse <= 1'b0;
         if (levelMv == '0) begin
            seenZero_reg <= 1'b1;
         end else if (seenZero_reg && levelMv >= POR_MV) begin
            seenZero_reg <= 1'b0;
            porPulse     <= 1'b1;
         end
      end
   end
endmodule

// ===== hdl/apm_mode_sequencer.sv
// Operating-mode sequencer of the amplifier: supply monitoring, modes, control registers.
// Assumes a 125 MHz ref_clk, inputs synchronous to it, and a simple strobe register port.
//
// Summary of operation
// - Supply ramp from zero triggers full reset
// - Exactly four modes exist
// - Low supply or reset pin forces power-down
// - Power-down refuses bus, clears all registers
// - Leave power-down when supplies good, pin high
// - Stand-by keeps only the bus alive
// - System on, amplifier off: configuring mode
// - Amplifier bit cleared: operating, stages start
// - Switching-stable flag set after start-up
// - Slot limits: eight, four at 96 kHz
// - Writing key to identity register resets
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module apm_mode_sequencer
   import apm_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_TIME_US * CLK_MHZ
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [MV_W-1:0]   vddLevelMv,
   input  wire logic [MV_W-1:0]   dvddLevelMv,
   input  wire logic              externalResetPinLow,
   input  wire logic              pllLocked,
   input  wire logic [ADDR_W-1:0] busAddr,
   input  wire logic [DATA_W-1:0] busWrData,
   input  wire logic              busWrStrobe,
   input  wire logic              busRdStrobe,
   output logic      [DATA_W-1:0] busRdData,
   output logic      [1:0]        modeState,
   output logic                   busPowered,
   output logic                   biasEnable,
   output logic                   oscEnable,
   output logic                   pllEnable,
   output logic                   boostEnable,
   output logic                   ampLoopEnable,
   output logic                   powerStageEnable,
   output logic                   outputFloating,
   output logic                   audioMuted,
   output logic                   irq
);
   localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);

   apm_mode_e          mode_reg;
   apm_mode_e          mode_next;
   logic               vddOk;
   logic               dvddOk;
   logic               vddPor;
   logic               dvddPor;
   logic               powerDown;
   logic               softReset_reg;
   logic               clearAll;
   logic [2:0]         system_control_reg_reg;
   logic [3:0]         slots_reg;
   logic [3:0]         rate_reg;
   logic [IRQ_W-1:0]   irqMask_reg;
   logic [IRQ_W-1:0]   irqStatus_reg;
   logic [IRQ_W-1:0]   irqEvent;
   logic [CNT_W-1:0]   startCnt_reg;
   logic               sws_reg;
   logic               pllSeen_reg;
   logic               busLive;
   logic               wrHit;
   logic               rdHit;
   logic [3:0]         wrSlots;
   logic [3:0]         wrRate;
   logic               wrCfgOk;
   logic               cfgOk;
   logic [DATA_W-1:0]  rdValue;

   // Hysteresis keeps a supply hovering near one figure from bouncing the mode
   apm_supply_mon #(
      .POR_MV (VDD_POR_MV),
      .OK_MV  (VDD_OK_MV)
   ) vddMon (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .levelMv  (vddLevelMv),
      .supplyOk (vddOk),
      .porPulse (vddPor)
   );

   apm_supply_mon #(
      .POR_MV (DVDD_POR_MV),
      .OK_MV  (DVDD_OK_MV)
   ) dvddMon (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .levelMv  (dvddLevelMv),
      .supplyOk (dvddOk),
      .porPulse (dvddPor)
   );

   // Any supply dip below its low figure or the pin low
   assign powerDown = !vddOk || !dvddOk || !externalResetPinLow;
   // Power-on pulse, soft reset and power-down all clear the configuration
   assign clearAll  = vddPor || dvddPor || powerDown || softReset_reg;

   // The bus is dead in power-down
   assign busLive = (mode_reg != MODE_POWER_DOWN) && !powerDown;
   assign wrHit   = busWrStrobe && busLive;
   assign rdHit   = busRdStrobe && busLive;

   // Four modes only
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_POWER_DOWN: begin
            mode_next = MODE_STANDBY;
         end
         MODE_STANDBY: begin
            if (!system_control_reg_reg[SC_SYS_PD_BIT]) begin
               mode_next = MODE_CONFIGURING;
            end
         end
         MODE_CONFIGURING: begin
            if (system_control_reg_reg[SC_SYS_PD_BIT]) begin
               mode_next = MODE_STANDBY;
            end else if (!system_control_reg_reg[SC_AMP_PD_BIT]) begin
               mode_next = MODE_OPERATING;
            end
         end
         MODE_OPERATING: begin
            if (system_control_reg_reg[SC_SYS_PD_BIT]) begin
               mode_next = MODE_STANDBY;
            end else if (system_control_reg_reg[SC_AMP_PD_BIT]) begin
               mode_next = MODE_CONFIGURING;
            end
         end
         default: begin
            mode_next = MODE_POWER_DOWN;
         end
      endcase
      // Faults beat any software request, whatever the mode
      if (powerDown || vddPor || dvddPor) begin
         mode_next = MODE_POWER_DOWN;
      end
   end

   // One step per cycle, so software cannot skip configuring on the way up
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= MODE_POWER_DOWN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Soft reset takes effect one cycle after the keyed write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         softReset_reg <= 1'b0;
      end else begin
         softReset_reg <= wrHit && busAddr == OFF_ID && busWrData == SOFT_RESET_KEY;
      end
   end

   // System control: both power-down bits and hard mute start set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         system_control_reg_reg <= SYSTEM_CONTROL_REG_RESET;
      end else if (clearAll) begin
         system_control_reg_reg <= SYSTEM_CONTROL_REG_RESET;
      end else if (wrHit && busAddr == OFF_SYSTEM_CONTROL_REG) begin
         system_control_reg_reg <= busWrData[2:0];
      end
   end

   // Audio port slot limits; a refused setting keeps the old one
   assign wrSlots = busWrData[AC_SLOTS_LSB +: 4];
   assign wrRate  = busWrData[AC_RATE_LSB +: 4];
   assign wrCfgOk = wrSlots != 4'h0 && wrRate <= RATE_96K
                    && (wrRate == RATE_96K ? wrSlots <= MAX_SLOTS_96K : wrSlots <= MAX_SLOTS);
   // Only the 96 kHz rate is checked, against four slots; every other rate reads as good
   assign cfgOk   = (rate_reg == RATE_96K) ? (slots_reg <= MAX_SLOTS_96K) : 1'b1;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slots_reg <= AC_SLOTS_RESET;
         rate_reg  <= RATE_48K;
      end else if (clearAll) begin
         slots_reg <= AC_SLOTS_RESET;
         rate_reg  <= RATE_48K;
      end else if (wrHit && busAddr == OFF_AUDCFG && wrCfgOk) begin
         slots_reg <= wrSlots;
         rate_reg  <= wrRate;
      end
   end

   // A set mask bit lets the matching status bit reach irq
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqMask_reg <= '0;
      end else if (clearAll) begin
         irqMask_reg <= '0;
      end else if (wrHit && busAddr == OFF_IRQMASK) begin
         irqMask_reg <= busWrData[IRQ_W-1:0];
      end
   end

   // Boost and amplifier start-up timer; flag falls when leaving operating
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         startCnt_reg <= '0;
         sws_reg      <= 1'b0;
      end else if (mode_reg != MODE_OPERATING || clearAll) begin
         startCnt_reg <= '0;
         sws_reg      <= 1'b0;
      end else if (startCnt_reg == CNT_W'(STARTUP_CYCLES - 1)) begin
         sws_reg      <= 1'b1;
      end else begin
         startCnt_reg <= startCnt_reg + CNT_W'(1);
      end
   end

   // PLL lock counts only while the PLL is powered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pllSeen_reg <= 1'b0;
      end else begin
         pllSeen_reg <= pllLocked && pllEnable;
      end
   end

   // One-cycle event strobes feeding the sticky status
   always_comb begin
      irqEvent                  = '0;
      irqEvent[IRQ_STANDBY_BIT] = mode_reg == MODE_POWER_DOWN && mode_next == MODE_STANDBY;
      irqEvent[IRQ_PLL_BIT]     = pllLocked && pllEnable && !pllSeen_reg;
      irqEvent[IRQ_SWS_BIT]     = mode_reg == MODE_OPERATING && !sws_reg && !clearAll
                                  && startCnt_reg == CNT_W'(STARTUP_CYCLES - 1);
      irqEvent[IRQ_CFGERR_BIT]  = wrHit && busAddr == OFF_AUDCFG && !wrCfgOk;
   end

   // Sticky events; read clears, but a new event in the same cycle wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStatus_reg <= '0;
      end else if (clearAll) begin
         irqStatus_reg <= irqEvent & (IRQ_W'(1) << IRQ_STANDBY_BIT);
      end else if (rdHit && busAddr == OFF_IRQST) begin
         irqStatus_reg <= irqEvent;
      end else begin
         irqStatus_reg <= irqStatus_reg | irqEvent;
      end
   end

   // Registered so the pin never glitches while status and mask change
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus_reg & irqMask_reg);
      end
   end

   // Unmapped offsets read as zero
   always_comb begin
      rdValue = '0;
      case (busAddr)
         OFF_ID: begin
            rdValue = ID_VALUE;
         end
         OFF_SYSTEM_CONTROL_REG: begin
            rdValue[2:0] = system_control_reg_reg;
         end
         OFF_SYSTEM_STATUS_REG: begin
            rdValue[ST_MODE_LSB +: 2]  = mode_reg;
            rdValue[ST_PLL_LOCK_BIT]   = pllSeen_reg;
            rdValue[ST_SWS_BIT]        = sws_reg;
            rdValue[ST_AUDCFG_OK_BIT]  = cfgOk;
            rdValue[ST_MUTED_BIT]      = audioMuted;
         end
         OFF_IRQST: begin
            rdValue[IRQ_W-1:0] = irqStatus_reg;
         end
         OFF_IRQMASK: begin
            rdValue[IRQ_W-1:0] = irqMask_reg;
         end
         OFF_AUDCFG: begin
            rdValue[AC_SLOTS_LSB +: 4] = slots_reg;
            rdValue[AC_RATE_LSB +: 4]  = rate_reg;
         end
         default: begin
            rdValue = '0;
         end
      endcase
   end

   // Refused reads return zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdData <= '0;
      end else if (rdHit) begin
         busRdData <= rdValue;
      end else begin
         busRdData <= '0;
      end
   end

   // Stage enables are registered from the next mode, so they never glitch
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         modeState        <= MODE_POWER_DOWN;
         busPowered       <= 1'b0;
         biasEnable       <= 1'b0;
         oscEnable        <= 1'b0;
         pllEnable        <= 1'b0;
         boostEnable      <= 1'b0;
         ampLoopEnable    <= 1'b0;
         powerStageEnable <= 1'b0;
         outputFloating   <= 1'b1;
      end else begin
         modeState        <= mode_next;
         busPowered       <= mode_next != MODE_POWER_DOWN;
         biasEnable       <= mode_next[1];
         oscEnable        <= mode_next[1];
         pllEnable        <= mode_next[1];
         boostEnable      <= mode_next == MODE_OPERATING;
         ampLoopEnable    <= mode_next == MODE_OPERATING;
         powerStageEnable <= mode_next == MODE_OPERATING;
         outputFloating   <= mode_next != MODE_OPERATING;
      end
   end

   // Muted whenever the hard mute is set or switching is not yet stable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         audioMuted <= 1'b1;
      end else begin
         audioMuted <= clearAll || system_control_reg_reg[SC_HARD_MUTE_BIT] || !sws_reg
                       || mode_reg != MODE_OPERATING;
      end
   end
endmodule

// ===== verification/apm_pll_model.sv
// Behavioural PLL beside the sequencer: lock after a settable delay.
// Assumes pllEnable comes from the sequencer on the same clock.
`timescale 1ns/1ps
module apm_pll_model #(
   parameter int LOCK_CYCLES = 8
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic pllEnable,
   output logic      pllLocked
);
   logic [15:0] lockCnt;

   // Lock is lost at once when disabled, so a stale lock never leaks
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lockCnt   <= 16'h0000;
         pllLocked <= 1'b0;
      end else if (!pllEnable) begin
         lockCnt   <= 16'h0000;
         pllLocked <= 1'b0;
      end else if (lockCnt == 16'(LOCK_CYCLES)) begin
         pllLocked <= 1'b1;
      end else begin
         lockCnt <= lockCnt + 16'h0001;
      end
   end
endmodule

// ===== verification/apm_mode_sequencer_chk.sv
// Checker of the mode outputs against supply, reset pin and bus inputs.
// Assumes it is bound into apm_mode_sequencer and sees only its ports.
`timescale 1ns/1ps
module apm_mode_sequencer_chk
   import apm_pkg::*;
#(
   parameter int STARTUP_CYCLES = 20
) (
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic [MV_W-1:0]   vddLevelMv,
   input wire logic [MV_W-1:0]   dvddLevelMv,
   input wire logic              externalResetPinLow,
   input wire logic              busRdStrobe,
   input wire logic [DATA_W-1:0] busRdData,
   input wire logic [1:0]        modeState,
   input wire logic              busPowered,
   input wire logic              biasEnable,
   input wire logic              oscEnable,
   input wire logic              pllEnable,
   input wire logic              boostEnable,
   input wire logic              ampLoopEnable,
   input wire logic              powerStageEnable,
   input wire logic              outputFloating,
   input wire logic              audioMuted
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic [31:0] opCnt;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         opCnt <= 32'h0;
      end else if (modeState == 2'b11) begin
         opCnt <= opCnt + 32'h1;
      end else begin
         opCnt <= 32'h0;
      end
   end

   sequence supBad;
      vddLevelMv < VDD_POR_MV || dvddLevelMv < DVDD_POR_MV || !externalResetPinLow;
   endsequence
   // Four good cycles cover the monitor delay before stand-by
   sequence supGood4;
      (vddLevelMv > VDD_OK_MV && dvddLevelMv > DVDD_OK_MV && externalResetPinLow) [*4];
   endsequence

   a_low_supply_down: assert property (supBad |-> ##[1:2] modeState == 2'b00)
      else $error("low supply or pin did not force power-down");
   a_down_bus_refused: assert property (modeState == 2'b00 && busRdStrobe |=>
      busRdData == 16'h0)
      else $error("read answered in power-down");
   a_down_all_off: assert property (modeState == 2'b00 |->
      !busPowered && !biasEnable && !boostEnable)
      else $error("logic powered in power-down");
   a_good_leaves_down: assert property (supGood4 |-> ##[0:2] modeState != 2'b00)
      else $error("power-down not left with good supplies");
   a_standby_bus_only: assert property (modeState == 2'b01 |->
      busPowered && !biasEnable && !boostEnable)
      else $error("stand-by powers more than the bus");
   a_config_biased: assert property (modeState == 2'b10 |->
      biasEnable && oscEnable && pllEnable && outputFloating && !boostEnable)
      else $error("configuring outputs wrong");
   a_oper_stages_on: assert property (modeState == 2'b11 |->
      boostEnable && ampLoopEnable && powerStageEnable && !outputFloating)
      else $error("operating stages not running");
   a_unmute_after_start: assert property ($fell(audioMuted) |->
      opCnt >= 32'(STARTUP_CYCLES))
      else $error("unmuted before start-up completed");
   a_muted_unless_oper: assert property (modeState != 2'b11 &&
      $past(modeState) != 2'b11 |-> audioMuted)
      else $error("audio unmuted outside operating");
endmodule

bind apm_mode_sequencer apm_mode_sequencer_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) apm_chk_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .vddLevelMv(vddLevelMv), .dvddLevelMv(dvddLevelMv),
   .externalResetPinLow(externalResetPinLow), .busRdStrobe(busRdStrobe), .busRdData(busRdData),
   .modeState(modeState), .busPowered(busPowered), .biasEnable(biasEnable),
   .oscEnable(oscEnable), .pllEnable(pllEnable), .boostEnable(boostEnable),
   .ampLoopEnable(ampLoopEnable), .powerStageEnable(powerStageEnable),
   .outputFloating(outputFloating), .audioMuted(audioMuted)
);

// ===== verification/apm_mode_sequencer_tb.sv
// Self-checking bench: supplies, reset pin and register accesses.
// Assumes the PLL model on the far side and a shortened start-up count.
`timescale 1ns/1ps
module apm_mode_sequencer_tb
   import apm_pkg::*;
;
   localparam int ST = 20;
   // Accepted entries keep fs legal and slots x 32 within 256 bit clocks
   localparam logic [15:0] CFG_VAL [7] = '{16'h0090, 16'h0089, 16'h00a2, 16'h0095,
                                           16'h0094, 16'h0068, 16'h0078};
   localparam logic [6:0]  CFG_OK = 7'b1110000;
   logic              refClk, external_reset_pin_low, pinHigh, pllLocked, wrStb, rdStb, busPowered, bias, osc;
   logic              pll, boost, ampLoop, stage, floating, muted, irq;
   logic [MV_W-1:0]   vdd, dvdd;
   logic [7:0]        addr;
   logic [15:0]       wdata, rdData, cfgCur;
   logic [1:0]        mode;
   int                errors, total_checks, n;

   apm_mode_sequencer #(.STARTUP_CYCLES(ST)) apm_mode_sequencer_inst (
      .ref_clk(refClk), .rst_n(external_reset_pin_low), .vddLevelMv(vdd), .dvddLevelMv(dvdd),
      .externalResetPinLow(pinHigh), .pllLocked(pllLocked), .busAddr(addr),
      .busWrData(wdata), .busWrStrobe(wrStb), .busRdStrobe(rdStb), .busRdData(rdData),
      .modeState(mode), .busPowered(busPowered), .biasEnable(bias), .oscEnable(osc),
      .pllEnable(pll), .boostEnable(boost), .ampLoopEnable(ampLoop),
      .powerStageEnable(stage), .outputFloating(floating), .audioMuted(muted), .irq(irq));
   apm_pll_model #(.LOCK_CYCLES(8)) apm_pll_model_inst (
      .ref_clk(refClk), .rst_n(external_reset_pin_low), .pllEnable(pll), .pllLocked(pllLocked));

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge refClk);
      addr  <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge refClk);
      wrStb <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge refClk);
      addr  <= a;
      rdStb <= 1'b1;
      @(posedge refClk);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask
   task automatic rdChk(input string what, input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask
   task automatic waitMode(input logic [1:0] m);
      int k;
      k = 0;
      while (mode !== m && k < 200) begin
         @(posedge refClk);
         #1 k++;
      end
      chk("mode", {14'h0, m}, {14'h0, mode});
      if (mode !== m) test_done();
   endtask
   task automatic pollSt(input int b, output int cnt);
      logic [15:0] s;
      cnt = 0;
      s = 16'h0000;
      while (s[b] !== 1'b1 && cnt < 100) begin
         rd(OFF_SYSTEM_STATUS_REG, s);
         cnt++;
      end
      chk("status bit", 16'h0001, {15'h0, s[b]});
      if (s[b] !== 1'b1) test_done();
   endtask

   initial begin
      refClk = 1'b0;
      forever #4 refClk = ~refClk;
   end
   initial begin
      repeat (20000) @(posedge refClk);
      errors++;
      $display("wrong value run length expected end seen hang");
      test_done();
   end

   initial begin
      external_reset_pin_low = 1'b0;
      vdd = '0;
      dvdd = '0;
      pinHigh = 1'b0;
      addr = '0;
      wdata = '0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      errors = 0;
      total_checks = 0;
      repeat (3) @(posedge refClk);
      external_reset_pin_low <= 1'b1;
      repeat (4) @(posedge refClk);
      wr(OFF_SYSTEM_CONTROL_REG, 16'h0000);
      rdChk("read in down", OFF_ID, 16'h0000);
      waitMode(2'b00);
      @(posedge refClk);
      vdd <= 13'd3300;
      dvdd <= 13'd1800;
      pinHigh <= 1'b1;
      waitMode(2'b01);
      chk("standby outs", 16'h0002, {14'h0, busPowered, bias});
      rdChk("id", OFF_ID, ID_VALUE);
      rdChk("system_control_reg", OFF_SYSTEM_CONTROL_REG, 16'h0007);
      rdChk("irq entry", OFF_IRQST, 16'h0001);
      rdChk("irq cleared", OFF_IRQST, 16'h0000);
      rdChk("audcfg", OFF_AUDCFG, 16'h0082);
      $display("test power-on done");
      cfgCur = 16'h0082;
      for (int i = 0; i < 7; i++) begin
         wr(OFF_AUDCFG, CFG_VAL[i]);
         if (CFG_OK[i]) cfgCur = CFG_VAL[i];
         rdChk("audcfg", OFF_AUDCFG, cfgCur);
         chk("irq", {15'h0, !CFG_OK[i] && i > 0}, {15'h0, irq});
         rdChk("irq cfg", OFF_IRQST, CFG_OK[i] ? 16'h0000 : 16'h0008);
         if (i == 0) wr(OFF_IRQMASK, 16'h0008);
      end
      rdChk("irq mask", OFF_IRQMASK, 16'h0008);
      $display("test audio config done");
      wr(OFF_SYSTEM_CONTROL_REG, 16'h0006);
      waitMode(2'b10);
      chk("config outs", 16'h001e, {11'h0, bias, osc, pll, floating, boost});
      pollSt(ST_PLL_LOCK_BIT, n);
      wr(OFF_SYSTEM_CONTROL_REG, 16'h0004);
      waitMode(2'b11);
      chk("oper outs", 16'h001f, {11'h0, boost, ampLoop, stage, !floating, muted});
      pollSt(ST_SWS_BIT, n);
      chk("start-up wait", 16'h0001, {15'h0, n >= ST / 2 - 2});
      chk("muted", 16'h0001, {15'h0, muted});
      wr(OFF_SYSTEM_CONTROL_REG, 16'h0000);
      repeat (3) @(posedge refClk);
      #1 chk("unmuted", 16'h0000, {15'h0, muted});
      rdChk("irq events", OFF_IRQST, 16'h0006);
      $display("test power-up done");
      @(posedge refClk);
      pinHigh <= 1'b0;
      waitMode(2'b00);
      chk("down outs", 16'h0001, {14'h0, busPowered, muted});
      rdChk("read in down", OFF_SYSTEM_CONTROL_REG, 16'h0000);
      @(posedge refClk);
      pinHigh <= 1'b1;
      waitMode(2'b01);
      rdChk("system_control_reg clear", OFF_SYSTEM_CONTROL_REG, 16'h0007);
      $display("test reset pin done");
      wr(OFF_SYSTEM_CONTROL_REG, 16'h0006);
      waitMode(2'b10);
      wr(OFF_AUDCFG, 16'h0094);
      wr(OFF_ID, SOFT_RESET_KEY);
      waitMode(2'b01);
      rdChk("system_control_reg soft", OFF_SYSTEM_CONTROL_REG, 16'h0007);
      rdChk("audcfg soft", OFF_AUDCFG, 16'h0082);
      $display("test soft reset done");
      @(posedge refClk);
      dvdd <= 13'd1000;
      waitMode(2'b00);
      $display("test supply dip done");
      test_done();
   end
endmodule
